// >>> rtl/timer8_core.v
// 8-bit timer/counter with two compare channels and an AXI4-Lite register port
// Assumes one clock; prescaler and crystal oscillator deliver tick enables
`timescale 1ns/1ps
`include "timer8_map.vh"

module timer8_core
(
    input wire ref_clk, // System clock, 40 MHz
    input wire sys_rst, // Synchronous reset, active high
    input wire [7:0] io_tick, // Prescaled io clock enables, per clock select
    input wire crystal_osc_tick, // Synchronised crystal oscillator tick
    input wire ack_overflow, // Overflow interrupt taken
    input wire ack_compare_a, // Compare A interrupt taken
    input wire ack_compare_b, // Compare B interrupt taken
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    output reg compare_output_a, // Compare output A register
    output reg compare_output_b, // Compare output B register
    output wire irq_overflow, // Overflow interrupt request
    output wire irq_compare_a, // Compare A interrupt request
    output wire irq_compare_b // Compare B interrupt request
);

// ============================================================
// Functions
// True for PWM waveform modes (bit0 set)
function is_pwm;
    input [2:0] mode;
    begin
        is_pwm = mode[0];
    end
endfunction

// Next value of a compare output for a match under an output mode
function match_level;
    input [2:0] mode;
    input [1:0] com;
    input cur;
    begin
        if (com == 2'h0)
            match_level = cur;
        else if (!is_pwm(mode))
            match_level = (com == 2'h1) ? ~cur : com[0];
        else if (com == 2'h1)
            match_level = cur;
        else
            match_level = com[0];
    end
endfunction

// ============================================================
// Registers
reg [7:0] control_reg_a;
reg [7:0] control_reg_b;
reg [7:0] async_status_reg;
reg [7:0] int_mask;
reg [2:0] flags;
reg [7:0] timer_count_value;
reg [7:0] compare_value_a;
reg [7:0] compare_value_b;
reg [7:0] buffer_a;
reg [7:0] buffer_b;
reg count_down;
reg block_match;
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

wire [2:0] waveform_mode_field;
wire [2:0] clock_select_field;
wire async_clock_select;
wire [1:0] compare_output_mode_a;
wire [1:0] compare_output_mode_b;
wire pwm;
wire phase_correct;
wire timer_tick;
wire [7:0] top_val;
wire at_top;
wire at_bottom;
wire at_max;
wire match_a;
wire match_b;
wire hit_a;
wire hit_b;
wire wr_fire;
wire wr_ok;
wire wr_count;
wire force_a;
wire force_b;
wire [7:0] wbyte;

// ============================================================
// Mode and tick decode
assign waveform_mode_field = {control_reg_b[`CRB_WGM2],
    control_reg_a[`CRA_WGM1], control_reg_a[`CRA_WGM0]};
assign clock_select_field = control_reg_b[`CRB_CS_LO+2:`CRB_CS_LO];
assign async_clock_select = async_status_reg[`ASR_AS];
assign compare_output_mode_a = control_reg_a[`CRA_COMA_LO+1:`CRA_COMA_LO];
assign compare_output_mode_b = control_reg_a[`CRA_COMB_LO+1:`CRA_COMB_LO];
assign pwm = is_pwm(waveform_mode_field);
assign phase_correct = pwm && !waveform_mode_field[1];
// Tick source: io prescaler or crystal; select zero stops
assign timer_tick = (clock_select_field == 3'h0) ? 1'b0 :
    (async_clock_select ? crystal_osc_tick :
    io_tick[clock_select_field]);

// Extremes
assign at_bottom = (timer_count_value == `BOTTOM_VAL);
assign at_max = (timer_count_value == `MAX_VAL);
assign top_val = (waveform_mode_field == `WGM_CTC ||
    waveform_mode_field[2]) ? compare_value_a : `MAX_VAL;
assign at_top = (timer_count_value == top_val);

// Comparator on both channels
assign match_a = (timer_count_value == compare_value_a);
assign match_b = (timer_count_value == compare_value_b);
// Tick that ends a cycle spent on a compare value
assign hit_a = timer_tick && match_a && !block_match && !wr_count;
assign hit_b = timer_tick && match_b && !block_match && !wr_count;

// ============================================================
// AXI4-Lite handshake
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign wr_fire = aw_held && w_held && !s_axi_bvalid;
assign wr_ok = wr_fire && (aw_addr <= `OFS_ASYNC_STATUS) &&
    (aw_addr[1:0] == 2'h0);
assign wbyte = w_data[7:0];
assign wr_count = wr_ok && (aw_addr == `OFS_COUNT) && w_strb[0];
// Strobes live one cycle only, never stored
assign force_a = wr_ok && (aw_addr == `OFS_CONTROL_REG_B) && w_strb[0] &&
    wbyte[`CRB_FOCA] && !pwm;
assign force_b = wr_ok && (aw_addr == `OFS_CONTROL_REG_B) && w_strb[0] &&
    wbyte[`CRB_FOCB] && !pwm;

// Write channel capture and response
always @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

// Read channel
always @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_CONTROL_REG_A: s_axi_rdata <= {24'h000000, control_reg_a};
            `OFS_CONTROL_REG_B: s_axi_rdata <= {24'h000000,
                2'h0, control_reg_b[5:0]};
            `OFS_COUNT: s_axi_rdata <= {24'h000000, timer_count_value};
            // Reads return what software wrote: buffer in PWM
            `OFS_COMPARE_A: s_axi_rdata <= {24'h000000,
                pwm ? buffer_a : compare_value_a};
            `OFS_COMPARE_B: s_axi_rdata <= {24'h000000,
                pwm ? buffer_b : compare_value_b};
            `OFS_INT_MASK: s_axi_rdata <= {24'h000000, int_mask};
            `OFS_INT_FLAGS: s_axi_rdata <= {29'h00000000, flags};
            `OFS_ASYNC_STATUS: s_axi_rdata <= {24'h000000,
                async_status_reg};
            default:
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

// ============================================================
// Control registers
always @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        control_reg_a <= `RESET_BYTE;
        control_reg_b <= `RESET_BYTE;
        async_status_reg <= `RESET_BYTE;
        int_mask <= `RESET_BYTE;
    end
    else if (wr_ok && w_strb[0])
    begin
        case (aw_addr)
            `OFS_CONTROL_REG_A: control_reg_a <= wbyte;
            `OFS_CONTROL_REG_B: control_reg_b <= {2'h0, wbyte[5:0]};
            `OFS_INT_MASK: int_mask <= {5'h00, wbyte[2:0]};
            `OFS_ASYNC_STATUS: async_status_reg <= wbyte & 8'h20;
            default: control_reg_a <= control_reg_a;
        endcase
    end
end

// ============================================================
// Counter unit
always @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        timer_count_value <= `BOTTOM_VAL;
        count_down <= 1'b0;
    end
    else if (wr_count)
        timer_count_value <= wbyte;
    else if (timer_tick)
    begin
        // Clear, step up or step down by mode
        if (phase_correct)
        begin
            if (!count_down && at_top)
            begin
                count_down <= 1'b1;
                timer_count_value <= timer_count_value - 8'h01;
            end
            else if (count_down && at_bottom)
            begin
                count_down <= 1'b0;
                timer_count_value <= timer_count_value + 8'h01;
            end
            else if (count_down)
                timer_count_value <= timer_count_value - 8'h01;
            else
                timer_count_value <= timer_count_value + 8'h01;
        end
        else
        begin
            count_down <= 1'b0;
            if (waveform_mode_field != `WGM_NORMAL && at_top)
                timer_count_value <= `BOTTOM_VAL;
            else
                timer_count_value <= timer_count_value + 8'h01;
        end
    end
end

// ============================================================
// Compare registers with optional double buffer
always @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        compare_value_a <= `RESET_BYTE;
        compare_value_b <= `RESET_BYTE;
        buffer_a <= `RESET_BYTE;
        buffer_b <= `RESET_BYTE;
    end
    else
    begin
        if (wr_ok && w_strb[0] && aw_addr == `OFS_COMPARE_A)
            buffer_a <= wbyte;
        if (wr_ok && w_strb[0] && aw_addr == `OFS_COMPARE_B)
            buffer_b <= wbyte;
        if (!pwm)
        begin
            // Direct access when unbuffered
            if (wr_ok && w_strb[0] && aw_addr == `OFS_COMPARE_A)
                compare_value_a <= wbyte;
            if (wr_ok && w_strb[0] && aw_addr == `OFS_COMPARE_B)
                compare_value_b <= wbyte;
        end
        else if (timer_tick && (phase_correct ? at_top : at_bottom))
        begin
            compare_value_a <= buffer_a;
            compare_value_b <= buffer_b;
        end
    end
end

// ============================================================
// Match blocking until the tick after a counter write
always @(posedge ref_clk)
begin
    if (sys_rst)
        block_match <= 1'b0;
    else if (wr_count)
        block_match <= 1'b1;
    else if (timer_tick)
        block_match <= 1'b0;
end

// ============================================================
// Flags: hardware set wins over clear
always @(posedge ref_clk)
begin
    if (sys_rst)
        flags <= 3'h0;
    else
    begin
        if (wr_ok && w_strb[0] && aw_addr == `OFS_INT_FLAGS)
            flags <= flags & ~wbyte[2:0];
        if (ack_overflow)
            flags[`FLG_OVF] <= 1'b0;
        if (ack_compare_a)
            flags[`FLG_CMPA] <= 1'b0;
        if (ack_compare_b)
            flags[`FLG_CMPB] <= 1'b0;
        // Overflow: wrap in non-PWM, top in fast, bottom in phase
        if (timer_tick && !wr_count &&
            (phase_correct ? (count_down && timer_count_value == 8'h01) :
            pwm ? at_top : at_max))
            flags[`FLG_OVF] <= 1'b1;
        if (hit_a)
            flags[`FLG_CMPA] <= 1'b1;
        if (hit_b)
            flags[`FLG_CMPB] <= 1'b1;
    end
end

assign irq_overflow = flags[`FLG_OVF] & int_mask[`FLG_OVF];
assign irq_compare_a = flags[`FLG_CMPA] & int_mask[`FLG_CMPA];
assign irq_compare_b = flags[`FLG_CMPB] & int_mask[`FLG_CMPB];

// ============================================================
// Waveform generator; outputs untouched by mode changes
always @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        compare_output_a <= 1'b0;
        compare_output_b <= 1'b0;
    end
    else
    begin
        if (force_a)
            compare_output_a <= match_level(waveform_mode_field,
                compare_output_mode_a, compare_output_a);
        else if (hit_a)
            compare_output_a <= match_level(waveform_mode_field,
                compare_output_mode_a ^ {1'b0, phase_correct &&
                count_down && compare_output_mode_a[1]},
                compare_output_a);
        else if (timer_tick && pwm && !phase_correct && at_top &&
            compare_output_mode_a[1])
            compare_output_a <= ~compare_output_mode_a[0];
        if (force_b)
            compare_output_b <= match_level(waveform_mode_field,
                compare_output_mode_b, compare_output_b);
        else if (hit_b)
            compare_output_b <= match_level(waveform_mode_field,
                compare_output_mode_b ^ {1'b0, phase_correct &&
                count_down && compare_output_mode_b[1]},
                compare_output_b);
        else if (timer_tick && pwm && !phase_correct && at_top &&
            compare_output_mode_b[1])
            compare_output_b <= ~compare_output_mode_b[0];
    end
end

endmodule // timer8_core

// >>> rtl/timer8_map.vh
// Register map, field positions, reset values and mode codes of the timer core
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

// Byte offsets
`define OFS_CONTROL_REG_A 8'h00
`define OFS_CONTROL_REG_B 8'h04
`define OFS_COUNT 8'h08
`define OFS_COMPARE_A 8'h0C
`define OFS_COMPARE_B 8'h10
`define OFS_INT_MASK 8'h14
`define OFS_INT_FLAGS 8'h18
`define OFS_ASYNC_STATUS 8'h1C

// control_reg_a fields
`define CRA_WGM0 0
`define CRA_WGM1 1
`define CRA_COMB_LO 4
`define CRA_COMA_LO 6
// control_reg_b fields
`define CRB_CS_LO 0
`define CRB_WGM2 3
`define CRB_FOCB 6
`define CRB_FOCA 7
// Flag and mask fields
`define FLG_OVF 0
`define FLG_CMPA 1
`define FLG_CMPB 2
// async_status_reg field
`define ASR_AS 5

// Reset values and extremes
`define BOTTOM_VAL 8'h00
`define MAX_VAL 8'hFF
`define RESET_BYTE 8'h00

// Waveform modes
`define WGM_NORMAL 3'h0
`define WGM_PC_MAX 3'h1
`define WGM_CTC 3'h2
`define WGM_FAST_MAX 3'h3
`define WGM_PC_OCRA 3'h5
`define WGM_FAST_OCRA 3'h7

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> tb/timer8_core_monitor.sv
// Port checker for timer8_core
// Assumes binding into timer8_core; sees only its ports
`timescale 1ns/1ps
module timer8_core_monitor
(
    input wire ref_clk, // Clock
    input wire sys_rst, // Reset
    input wire [7:0] io_tick, // Io ticks
    input wire crystal_osc_tick, // Crystal tick
    input wire ack_compare_a, // Flag A taken
    input wire s_axi_awvalid, // Aw valid
    input wire s_axi_awready, // Aw ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire s_axi_bvalid, // B valid
    input wire s_axi_bready, // B ready
    input wire s_axi_arvalid, // Ar valid
    input wire s_axi_arready, // Ar ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire s_axi_rvalid, // R valid
    input wire s_axi_rready, // R ready
    input wire compare_output_a, // Output A
    input wire irq_overflow, // Overflow request
    input wire irq_compare_a // Compare A request
);
    // ====
    // Shared timing
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Any timer tick source active
    wire any_tick = |io_tick || crystal_osc_tick;
    // ====
    // Bus answers
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_reset_clean: assert property ($fell(sys_rst) |-> !compare_output_a
        && !irq_overflow && !irq_compare_a) else $error("reset state");
    // ====
    // Timer events
    a_ovf_on_tick: assert property ($rose(irq_overflow)
        |-> $past(any_tick) || $rose(s_axi_bvalid))
        else $error("overflow without tick");
    a_flag_on_tick: assert property ($rose(irq_compare_a)
        |-> $past(any_tick) || $rose(s_axi_bvalid))
        else $error("compare flag without tick");
    a_flag_clear: assert property ($fell(irq_compare_a)
        |-> $past(ack_compare_a) || $rose(s_axi_bvalid) || $past(sys_rst))
        else $error("compare flag lost");
    a_output_cause: assert property (!$stable(compare_output_a)
        |-> $past(any_tick) || $rose(s_axi_bvalid) || $past(sys_rst))
        else $error("output changed alone");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_overflow: cover property ($rose(irq_overflow));
    c_compare: cover property ($rose(irq_compare_a));
    c_output: cover property (!$stable(compare_output_a));
endmodule // timer8_core_monitor

// >>> tb/timer8_core_tb_top.sv
// Self-checking bench for timer8_core
// Assumes the register map header and a 40 MHz ref_clk
`timescale 1ns/1ps
`include "timer8_map.vh"
module timer8_core_tb_top;
    reg ref_clk = 1'h0;
    reg sys_rst = 1'h1;
    reg [7:0] io_tick = 8'h00;
    reg crystal_osc_tick = 1'h0;
    reg ack_compare_a = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg s_axi_awvalid = 1'h0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_wvalid = 1'h0;
    reg s_axi_bready = 1'h0;
    reg [7:0] s_axi_araddr = 8'h00;
    reg s_axi_arvalid = 1'h0;
    reg s_axi_rready = 1'h0;
    wire s_axi_awready;
    wire s_axi_wready;
    wire [1:0] s_axi_bresp;
    wire s_axi_bvalid;
    wire s_axi_arready;
    wire [31:0] s_axi_rdata;
    wire [1:0] s_axi_rresp;
    wire s_axi_rvalid;
    wire compare_output_a;
    wire compare_output_b;
    wire irq_overflow;
    wire irq_compare_a;
    wire irq_compare_b;
    reg [1:0] resp;
    reg [31:0] rdat;
    integer n_errors = 0;
    integer tests_run = 0;
    integer i;
    // Design under test, unused acks tied idle
    timer8_core timer8_core_i (.ack_overflow(1'h0), .ack_compare_b(1'h0),
        .s_axi_wstrb(4'hF), .*);
    // 25 ns clock
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ====
    // Shared tasks
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e)
            begin
                n_errors = n_errors + 1;
                $display("wrong value %s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d, errors %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Bus write; bready stands with the request until the answer
    task wr(input [7:0] a, input [7:0] d);
        integer k;
        begin
            @(posedge ref_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            for (k = 0; k < 40; k = k + 1)
            begin
                @(posedge ref_clk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'h0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'h0;
                if (s_axi_bvalid)
                begin
                    resp = s_axi_bresp;
                    s_axi_bready <= 1'h0;
                    k = 99;
                end
            end
            if (k != 100)
            begin
                chk("write answer", 1, 0);
                end_of_test;
            end
        end
    endtask
    // Bus read into rdat
    task rd(input [7:0] a);
        integer k;
        begin
            @(posedge ref_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            for (k = 0; k < 40; k = k + 1)
            begin
                @(posedge ref_clk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'h0;
                if (s_axi_rvalid)
                begin
                    resp = s_axi_rresp;
                    rdat = s_axi_rdata;
                    s_axi_rready <= 1'h0;
                    k = 99;
                end
            end
            if (k != 100)
            begin
                chk("read answer", 1, 0);
                end_of_test;
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            rd(a);
            chk("read data", e, rdat);
        end
    endtask
    // n one-cycle ticks, pattern is {crystal, io}
    task tk(input integer n, input [8:0] p);
        begin
            repeat (n)
            begin
                @(posedge ref_clk);
                {crystal_osc_tick, io_tick} <= p;
                @(posedge ref_clk);
                {crystal_osc_tick, io_tick} <= 9'h000;
            end
            @(posedge ref_clk);
        end
    endtask
    // ====
    // Scenarios
    task t_regs;
        begin
            for (i = 0; i < 8; i = i + 1)
                rdc(i * 4, 0);
            rd(8'h20);
            chk("read resp", `RESP_SLVERR, resp);
            wr(8'h20, 8'h11);
            chk("write resp", `RESP_SLVERR, resp);
        end
    endtask
    task t_count;
        begin
            wr(`OFS_INT_MASK, 8'h01);
            wr(`OFS_COUNT, 8'hFE);
            wr(`OFS_CONTROL_REG_B, 8'h01);
            tk(1, 9'h002);
            rdc(`OFS_COUNT, 8'hFF);
            chk("overflow", 0, irq_overflow);
            tk(1, 9'h002);
            rdc(`OFS_COUNT, 8'h00);
            chk("overflow", 1, irq_overflow);
            wr(`OFS_INT_FLAGS, 8'h01);
            chk("overflow", 0, irq_overflow);
            wr(`OFS_CONTROL_REG_B, 8'h00);
            wr(`OFS_COUNT, 8'h33);
            tk(2, 9'h002);
            rdc(`OFS_COUNT, 8'h33);
            wr(`OFS_CONTROL_REG_B, 8'h01);
            io_tick <= 8'h02;
            wr(`OFS_COUNT, 8'h40);
            io_tick <= 8'h00;
            rdc(`OFS_COUNT, 8'h41);
            wr(`OFS_ASYNC_STATUS, 8'h20);
            tk(1, 9'h0FF);
            rdc(`OFS_COUNT, 8'h41);
            tk(1, 9'h100);
            rdc(`OFS_COUNT, 8'h42);
            wr(`OFS_ASYNC_STATUS, 8'h00);
        end
    endtask
    task t_compare;
        begin
            wr(`OFS_COMPARE_A, 8'h03);
            wr(`OFS_COMPARE_B, 8'h02);
            wr(`OFS_INT_MASK, 8'h06);
            wr(`OFS_CONTROL_REG_A, 8'h52);
            wr(`OFS_COUNT, 8'h00);
            tk(3, 9'h002);
            chk("flag a", 0, irq_compare_a);
            chk("flag b", 1, irq_compare_b);
            chk("output b", 1, compare_output_b);
            tk(1, 9'h002);
            rdc(`OFS_COUNT, 8'h00);
            chk("flag a", 1, irq_compare_a);
            chk("output a", 1, compare_output_a);
            ack_compare_a <= 1'h1;
            @(posedge ref_clk);
            ack_compare_a <= 1'h0;
            @(posedge ref_clk);
            @(posedge ref_clk);
            chk("flag a", 0, irq_compare_a);
            wr(`OFS_INT_FLAGS, 8'h04);
            chk("flag b", 0, irq_compare_b);
            wr(`OFS_CONTROL_REG_A, 8'h00);
            wr(`OFS_COMPARE_A, 8'h10);
            wr(`OFS_CONTROL_REG_B, 8'h00);
            wr(`OFS_COUNT, 8'h10);
            wr(`OFS_CONTROL_REG_B, 8'h01);
            tk(2, 9'h002);
            chk("flag a", 0, irq_compare_a);
            rdc(`OFS_COUNT, 8'h12);
            wr(`OFS_CONTROL_REG_B, 8'h00);
        end
    endtask
    task t_force;
        begin
            wr(`OFS_CONTROL_REG_A, 8'h40);
            wr(`OFS_CONTROL_REG_B, 8'h80);
            chk("output a", 0, compare_output_a);
            chk("flag a", 0, irq_compare_a);
            rdc(`OFS_COUNT, 8'h12);
            rdc(`OFS_CONTROL_REG_B, 8'h00);
            wr(`OFS_CONTROL_REG_A, 8'h00);
            wr(`OFS_CONTROL_REG_B, 8'h80);
            chk("output a", 0, compare_output_a);
            wr(`OFS_CONTROL_REG_A, 8'h40);
            wr(`OFS_CONTROL_REG_B, 8'h80);
            chk("output a", 1, compare_output_a);
            wr(`OFS_CONTROL_REG_A, 8'h43);
            wr(`OFS_CONTROL_REG_B, 8'h80);
            chk("output a", 1, compare_output_a);
        end
    endtask
    task t_buffer;
        begin
            wr(`OFS_CONTROL_REG_A, 8'h00);
            wr(`OFS_COMPARE_B, 8'h20);
            wr(`OFS_CONTROL_REG_A, 8'h03);
            wr(`OFS_COMPARE_B, 8'h12);
            wr(`OFS_INT_MASK, 8'h04);
            wr(`OFS_INT_FLAGS, 8'h07);
            wr(`OFS_COUNT, 8'h10);
            wr(`OFS_CONTROL_REG_B, 8'h01);
            tk(3, 9'h002);
            chk("flag b", 0, irq_compare_b);
            wr(`OFS_COUNT, 8'hFE);
            tk(21, 9'h002);
            rdc(`OFS_COUNT, 8'h13);
            chk("flag b", 1, irq_compare_b);
            wr(`OFS_CONTROL_REG_A, 8'h01);
            wr(`OFS_COUNT, 8'hFE);
            tk(3, 9'h002);
            rdc(`OFS_COUNT, 8'hFD);
        end
    endtask
    // ====
    // Main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'h0;
        t_regs;
        t_count;
        t_compare;
        t_force;
        t_buffer;
        end_of_test;
    end
endmodule // timer8_core_tb_top
bind timer8_core timer8_core_monitor timer8_core_monitor_i (.*);
